// File: rtl/adsc_defs.svh
// Register map, field positions, reset values and timing of the sense block
`ifndef ADSC_DEFS_SVH
`define ADSC_DEFS_SVH

// Register indices; byte address is four times the index
`define ADSC_IDX_CTL1      8'h2d
`define ADSC_IDX_CTL2      8'h2e
`define ADSC_IDX_DATA      8'h2f

// First control register fields
`define ADSC_C1_CH_MSB     7
`define ADSC_C1_CH_LSB     4
`define ADSC_C1_IRQ        3
`define ADSC_C1_BUSY       2
`define ADSC_C1_CMP        1
`define ADSC_C1_START      0

// Second control register fields
`define ADSC_C2_TRIG       4
`define ADSC_C2_IRQEN      3
`define ADSC_C2_FUNC       2
`define ADSC_C2_CONT       1
`define ADSC_C2_RESERVED_ONE       0

// Reset values
`define ADSC_CH_RST        4'h0
`define ADSC_BYTE_RST      8'h00
`define ADSC_RESERVED_ONE_VAL      1'b1

// Timing: clock period and instruction cycle in ns, durations in cycles
`define ADSC_CLK_NS        100
`define ADSC_ICYC_NS       100
`define ADSC_SENSE_ICYC    12
`define ADSC_SAMPLE_ICYC   8
`define ADSC_CONV_ICYC     44
`define ADSC_SENSE_CYC     ((`ADSC_SENSE_ICYC * `ADSC_ICYC_NS) / `ADSC_CLK_NS)
`define ADSC_SAMPLE_CYC    ((`ADSC_SAMPLE_ICYC * `ADSC_ICYC_NS) / `ADSC_CLK_NS)
`define ADSC_CONV_CYC      ((`ADSC_CONV_ICYC * `ADSC_ICYC_NS) / `ADSC_CLK_NS)

// AXI responses
`define ADSC_RESP_OKAY     2'h0
`define ADSC_RESP_SLVERR   2'h2

`endif

// File: rtl/adsc_pkg.sv
// Types shared by the sense block
`default_nettype none
package adsc_pkg;

    typedef enum logic [2:0] {
        ADSC_IDLE    = 3'b001,
        ADSC_SAMPLE  = 3'b010,
        ADSC_COMPARE = 3'b100
    } adsc_state_type;

    typedef enum logic [1:0] {
        ADSC_REG_CTL1 = 2'h0,
        ADSC_REG_CTL2 = 2'h1,
        ADSC_REG_DATA = 2'h2,
        ADSC_REG_NONE = 2'h3
    } adsc_reg_type;

endpackage : adsc_pkg
`default_nettype wire

// File: rtl/adsc_ctrl.sv
// Sense and conversion control of an 8-bit converter, AXI4-Lite registers
//
// Notes on behaviour
// - Sense takes twelve cycles, start to end
// - Start raises busy, routes selected channel
// - Sample eight cycles, then hold level
// - Compare held sample against loaded threshold
// - Sense sets flag only on condition match
// - No flag on mismatch; busy clears at end
// - Continuous: trigger rising edge starts operation
// - Continuous off: only software starts remain
// - Writing start bit begins an operation
// - Reset initialises everything; stop mode all but the bus interface
// - Conversion result held until next conversion ends
// - Software restart coinciding with completion sets no flag
// - Request stays high while flag and enable
// - Trigger selects timer or timebase output
// - Control one: flag 3, busy 2, start 0
// - Control two: continuous enable at bit 1
// - Condition zero: lower input is a match
// - Request forwarded when flag and enable
// - Data write sets threshold in sense mode, read gives result
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defs.svh"

module adsc_ctrl
    import adsc_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NCH    = 8
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 stop_mode,
    input  wire logic [NCH*8-1:0]     ain_levels,
    input  wire logic                 trig_timer,
    input  wire logic                 trig_timebase,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 wvalid,
    output logic                      wready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    output logic                      bvalid,
    input  wire logic                 bready,
    output logic [1:0]                bresp,
    input  wire logic                 arvalid,
    output logic                      arready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic [2:0]           arprot,
    output logic                      rvalid,
    input  wire logic                 rready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic [3:0]                sh_route,
    output logic                      sh_sampling,
    output logic                      converter_irq_line
);

    localparam logic [5:0] SENSE_CYC  = 6'(`ADSC_SENSE_CYC);
    localparam logic [5:0] SAMPLE_CYC = 6'(`ADSC_SAMPLE_CYC);
    localparam logic [5:0] CONV_CYC   = 6'(`ADSC_CONV_CYC);
    ////////////////////////////////////////////////////////////////////////
    function automatic adsc_reg_type decode(input logic [ADDR_W-1:0] a);
        logic [9:0] ba;
        ba = 10'(a);
        if (32'(a) != 32'(ba))
            decode = ADSC_REG_NONE;
        else if (ba == {`ADSC_IDX_CTL1, 2'b00})
            decode = ADSC_REG_CTL1;
        else if (ba == {`ADSC_IDX_CTL2, 2'b00})
            decode = ADSC_REG_CTL2;
        else if (ba == {`ADSC_IDX_DATA, 2'b00})
            decode = ADSC_REG_DATA;
        else
            decode = ADSC_REG_NONE;
    endfunction : decode
    // Strict compare: equality never matches
    function automatic logic sense_match(input logic [7:0] lvl,
                                         input logic [7:0] thr,
                                         input logic       above);
        sense_match = above ? (lvl > thr) : (lvl < thr);
    endfunction : sense_match

    function automatic logic [7:0] pick(input logic [NCH*8-1:0] lv,
                                        input logic [3:0]       ch);
        pick = 8'h00;
        for (int i = 0; i < NCH; i++) begin
            if (32'(ch) == i)
                pick = lv[i*8 +: 8];
        end
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    logic           rst_w;
    adsc_state_type state_r;
    logic [5:0]     cnt_r;
    logic [7:0]     hold_r;
    logic [7:0]     res_r;
    logic [7:0]     thr_r;
    logic [3:0]     ch_sel_r;
    logic           irq_flag_r;
    logic           cmp_cond_r;
    logic           trig_sel_r;
    logic           irq_en_r;
    logic           func_sel_r;
    logic           cont_en_r;
    logic [3:0]     route_r;
    logic           trig_prev_r;
    logic           aw_full_r;
    logic           w_full_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]    wdata_r;
    logic [3:0]     wstrb_r;
    logic           bvalid_r;
    logic [1:0]     bresp_r;
    logic           rvalid_r;
    logic [31:0]    rdata_r;
    logic [1:0]     rresp_r;

    logic           wr_do;
    adsc_reg_type   wr_reg;
    logic           wr_lane0;
    logic           wr_ctl1;
    logic           wr_ctl2;
    logic           sw_start;
    logic           trig_now;
    logic           trig_edge;
    logic           start_w;
    logic           busy_flag;
    logic [5:0]     total_w;
    logic           done_w;
    logic           match_w;
    logic           event_w;

    assign rst_w = !aresetn || stop_mode;
    ////////////////////////////////////////////////////////////////////////
    assign awready = !aw_full_r;
    assign wready  = !w_full_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign wr_do   = aw_full_r && w_full_r && !bvalid_r;
    assign wr_reg  = decode(awaddr_r);
    assign wr_lane0 = wr_do && wstrb_r[0];
    assign wr_ctl1 = wr_lane0 && (wr_reg == ADSC_REG_CTL1);
    assign wr_ctl2 = wr_lane0 && (wr_reg == ADSC_REG_CTL2);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= awaddr;
        end else if (wr_do) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
        end else if (wr_do) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `ADSC_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_reg == ADSC_REG_NONE) ? `ADSC_RESP_SLVERR
                                                  : `ADSC_RESP_OKAY;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign arready = !rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `ADSC_RESP_OKAY;
        end else if (arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `ADSC_RESP_OKAY;
            case (decode(araddr))
                ADSC_REG_CTL1: begin
                    rdata_r <= {24'h0, ch_sel_r, irq_flag_r, busy_flag,
                                cmp_cond_r, 1'b0};
                end
                ADSC_REG_CTL2: begin
                    rdata_r <= {27'h0, trig_sel_r, irq_en_r, func_sel_r,
                                cont_en_r, `ADSC_RESERVED_ONE_VAL};
                end
                ADSC_REG_DATA: rdata_r <= {24'h0, res_r};
                default: begin
                    rdata_r <= '0;
                    rresp_r <= `ADSC_RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (rst_w) begin
            ch_sel_r   <= `ADSC_CH_RST;
            cmp_cond_r <= 1'b0;
        end else if (wr_ctl1) begin
            ch_sel_r   <= wdata_r[`ADSC_C1_CH_MSB:`ADSC_C1_CH_LSB];
            cmp_cond_r <= wdata_r[`ADSC_C1_CMP];
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_w) begin
            trig_sel_r <= 1'b0;
            irq_en_r   <= 1'b0;
            func_sel_r <= 1'b0;
            cont_en_r  <= 1'b0;
        end else if (wr_ctl2) begin
            trig_sel_r <= wdata_r[`ADSC_C2_TRIG];
            irq_en_r   <= wdata_r[`ADSC_C2_IRQEN];
            func_sel_r <= wdata_r[`ADSC_C2_FUNC];
            cont_en_r  <= wdata_r[`ADSC_C2_CONT];
        end
    end

    // Threshold is write-only, and only in sense mode
    always_ff @(posedge aclk) begin
        if (rst_w)
            thr_r <= `ADSC_BYTE_RST;
        else if (wr_lane0 && wr_reg == ADSC_REG_DATA && func_sel_r)
            thr_r <= wdata_r[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    assign sw_start  = wr_ctl1 && wdata_r[`ADSC_C1_START];
    assign trig_now  = trig_sel_r ? trig_timebase : trig_timer;
    assign trig_edge = trig_now && !trig_prev_r;
    assign start_w   = sw_start || (cont_en_r && trig_edge);

    always_ff @(posedge aclk) begin
        if (rst_w)
            trig_prev_r <= 1'b0;
        else
            trig_prev_r <= trig_now;
    end

    ////////////////////////////////////////////////////////////////////////
    assign busy_flag = (state_r != ADSC_IDLE);
    assign total_w   = func_sel_r ? SENSE_CYC : CONV_CYC;
    assign done_w    = (state_r == ADSC_COMPARE) && (cnt_r == total_w);
    assign match_w   = sense_match(hold_r, thr_r, cmp_cond_r);

    // A restart always wins over the current operation
    always_ff @(posedge aclk) begin
        if (rst_w) begin
            state_r <= ADSC_IDLE;
            cnt_r   <= 6'h0;
        end else if (start_w) begin
            state_r <= ADSC_SAMPLE;
            cnt_r   <= 6'h1;
        end else begin
            case (state_r)
                ADSC_IDLE: cnt_r <= 6'h0;
                ADSC_SAMPLE: begin
                    cnt_r <= cnt_r + 6'h1;
                    if (cnt_r == SAMPLE_CYC)
                        state_r <= ADSC_COMPARE;
                end
                ADSC_COMPARE: begin
                    cnt_r <= cnt_r + 6'h1;
                    if (done_w)
                        state_r <= ADSC_IDLE;
                end
                default: begin
                    state_r <= ADSC_IDLE;
                    cnt_r   <= 6'h0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_w)
            hold_r <= `ADSC_BYTE_RST;
        else if (state_r == ADSC_SAMPLE)
            hold_r <= pick(ain_levels, route_r);
    end

    always_ff @(posedge aclk) begin
        if (rst_w)
            route_r <= `ADSC_CH_RST;
        else if (start_w)
            route_r <= ch_sel_r;
    end

    assign sh_route    = route_r;
    assign sh_sampling = (state_r == ADSC_SAMPLE);

    always_ff @(posedge aclk) begin
        if (rst_w)
            res_r <= `ADSC_BYTE_RST;
        else if (done_w && !func_sel_r)
            res_r <= hold_r;
    end

    ////////////////////////////////////////////////////////////////////////
    assign event_w = done_w && (func_sel_r ? match_w : 1'b1);

    // Set wins over a write of zero; a coinciding software restart drops the set
    always_ff @(posedge aclk) begin
        if (rst_w)
            irq_flag_r <= 1'b0;
        else if (event_w && !sw_start)
            irq_flag_r <= 1'b1;
        else if (wr_ctl1 && !wdata_r[`ADSC_C1_IRQ])
            irq_flag_r <= 1'b0;
    end

    assign converter_irq_line = irq_flag_r && irq_en_r;

    ////////////////////////////////////////////////////////////////////////
    logic [5:0] act_cnt_r;
    always_ff @(posedge aclk) begin
        if (rst_w)
            act_cnt_r <= 6'h0;
        else if (start_w)
            act_cnt_r <= 6'h1;
        else if (busy_flag)
            act_cnt_r <= act_cnt_r + 6'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (rst_w);
    // Sampling ended by the sequencer, not by a stop
    sequence s_sample_end;
        $fell(sh_sampling) && !$past(rst_w);
    endsequence
    sense_time_a: assert property ($fell(busy_flag) && func_sel_r
        |-> $past(act_cnt_r) == 6'h0c)
        else $error("sense duration not twelve cycles");
    start_route_a: assert property (start_w
        |=> busy_flag && sh_route == $past(ch_sel_r))
        else $error("start did not raise busy and route channel");
    hold_frozen_a: assert property (!sh_sampling |=> $stable(hold_r))
        else $error("held sample changed outside sampling");
    sample_seq_a: assert property (s_sample_end
        |-> $past(act_cnt_r) == 6'h08)
        else $error("sampling window not eight cycles");
    match_set_a: assert property (done_w && func_sel_r && match_w
        && !sw_start |=> irq_flag_r)
        else $error("match did not set flag");
    nomatch_a: assert property (done_w && func_sel_r && !match_w
        && !irq_flag_r |=> !irq_flag_r)
        else $error("flag set without match");
    busy_end_a: assert property (done_w && !start_w |=> !busy_flag)
        else $error("busy did not clear at end");
    start_src_a: assert property ($rose(busy_flag)
        |-> $past(sw_start) || ($past(cont_en_r) && $past(trig_edge)))
        else $error("start without a source");
    race_a: assert property (done_w && sw_start && !irq_flag_r
        |=> !irq_flag_r)
        else $error("flag set despite restart");
    irq_line_a: assert property (irq_flag_r && irq_en_r
        && !wr_ctl1 && !wr_ctl2 |=> converter_irq_line)
        else $error("request dropped while flag set");
    cond_low_a: assert property (done_w && func_sel_r && !cmp_cond_r
        && hold_r >= thr_r && !irq_flag_r |=> !irq_flag_r)
        else $error("lower-input condition violated");
    conv_res_a: assert property (done_w && !func_sel_r
        |=> res_r == $past(hold_r))
        else $error("conversion result not stored");

endmodule : adsc_ctrl

`default_nettype wire

// File: tb/adsc_far_side.sv
// Far-side model: analog channel levels and trigger clock sources
`timescale 1ns/1ps
`default_nettype none

module adsc_far_side (
    input  wire logic        aclk,
    input  wire logic [7:0]  lvl,
    input  wire logic [2:0]  ch,
    input  wire logic [1:0]  run,
    output logic [63:0]      ain_levels,
    output logic             trig_timer,
    output logic             trig_timebase
);
    logic [5:0] cnt_r = 6'h00;

    // Chosen channel carries lvl, every other one its inverse
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ain_levels[8*i +: 8] = (i == ch) ? lvl : ~lvl;
        end
    end

    // Two trigger sources, each held low while not running
    always_ff @(posedge aclk) begin
        cnt_r         <= cnt_r + 6'h01;
        trig_timer    <= run[0] & cnt_r[4];
        trig_timebase <= run[1] & cnt_r[5];
    end
endmodule : adsc_far_side
`default_nettype wire

// File: tb/adc_sense_compare_control_tb_top.sv
// Self-checking bench for the sense and conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defs.svh"

module adc_sense_compare_control_tb_top;
    localparam logic [7:0] c1 = `ADSC_IDX_CTL1;
    localparam logic [7:0] c2 = `ADSC_IDX_CTL2;
    localparam logic [7:0] cd = `ADSC_IDX_DATA;

    logic        aclk = 1'b0, aresetn = 1'b0, stop_mode = 1'b0;
    logic [63:0] ain_levels;
    logic        trig_timer, trig_timebase;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, wr_resp, rd_resp;
    logic [31:0] rdata, rd_data;
    logic [3:0]  sh_route;
    logic        sh_sampling, converter_irq_line;
    logic [7:0]  lvl = 8'h00;
    logic [2:0]  ch = 3'h0;
    logic [1:0]  run = 2'h0;
    logic        samp_d = 1'b0;
    int          error_cnt = 0, check_count = 0;
    int          samp_run = 0, samp_len = 0, samp_starts = 0;

    always #50 aclk = ~aclk;

    adsc_ctrl #(.ADDR_W(12), .NCH(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .stop_mode(stop_mode),
        .ain_levels(ain_levels), .trig_timer(trig_timer),
        .trig_timebase(trig_timebase), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h1),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .sh_route(sh_route), .sh_sampling(sh_sampling),
        .converter_irq_line(converter_irq_line));

    adsc_far_side u_far (
        .aclk(aclk), .lvl(lvl), .ch(ch), .run(run),
        .ain_levels(ain_levels), .trig_timer(trig_timer),
        .trig_timebase(trig_timebase));

    // Sampling window length and count of operation starts
    always @(negedge aclk) begin
        samp_d <= sh_sampling;
        if (sh_sampling) samp_run <= samp_run + 1;
        else if (samp_d) begin
            samp_len <= samp_run;
            samp_run <= 0;
        end
        if (sh_sampling && !samp_d) samp_starts <= samp_starts + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string nm, input logic [31:0] exp,
                           input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(negedge aclk);
            a_ok = a_ok | (awvalid & awready);
            w_ok = w_ok | (wvalid & wready);
            @(posedge aclk);
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        wr_resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                         input string nm);
        rd(idx);
        chk_val(nm, {24'h000000, exp}, rd_data);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk(c1, 8'h00, "ctl1 reset");
        rdchk(c2, 8'h01, "ctl2 reset");
        chk_val("irq line reset", 0, converter_irq_line);
        rd(8'h30);
        chk_val("unmapped rresp", `ADSC_RESP_SLVERR, rd_resp);
        wr(8'h2c, 8'hff);
        chk_val("unmapped bresp", `ADSC_RESP_SLVERR, wr_resp);
    endtask : t_reset

    task automatic t_sense;
        logic [7:0] tab [6] = '{8'h80, 8'hc0, 8'h80, 8'h40, 8'hc0, 8'h40};
        logic [1:0] ce [6] = '{2'b00, 2'b00, 2'b10, 2'b10, 2'b11, 2'b01};
        logic [7:0] ctl;
        int n0;
        wr(c2, 8'h0d);
        wr(cd, 8'h80);
        for (int i = 0; i < 6; i++) begin
            ch  <= i[2:0];
            lvl <= tab[i];
            ctl = {i[3:0], 2'b00, ce[i][1], 1'b0};
            wr(c1, ctl);
            n0 = samp_starts;
            wr(c1, ctl | 8'h01);
            rdchk(c1, ctl | 8'h04, "busy");
            chk_val("route", i, sh_route);
            while (sh_sampling || samp_starts == n0) @(negedge aclk);
            @(posedge aclk);
            lvl <= ~tab[i];
            repeat (14) @(posedge aclk);
            chk_val("sample length", 8, samp_len);
            ctl = ctl | {4'h0, ce[i][0], 3'h0};
            rdchk(c1, ctl, "result");
            chk_val("irq line", ce[i][0], converter_irq_line);
        end
    endtask : t_sense

    task automatic t_irq;
        wr(c2, 8'h05);
        chk_val("irq masked", 0, converter_irq_line);
        wr(c2, 8'h0d);
        chk_val("irq held", 1, converter_irq_line);
        wr(c1, 8'h58);
        rdchk(c1, 8'h58, "flag write one");
        wr(c1, 8'h50);
        rdchk(c1, 8'h50, "flag write zero");
        chk_val("irq cleared", 0, converter_irq_line);
    endtask : t_irq

    task automatic t_cont;
        int n0;
        for (int s = 0; s < 2; s++) begin
            wr(c2, {3'h0, s[0], 4'hf});
            run <= s[0] ? 2'b01 : 2'b10;
            n0 = samp_starts;
            repeat (130) @(posedge aclk);
            chk_val("other trigger", n0, samp_starts);
            run <= s[0] ? 2'b10 : 2'b01;
            repeat (130) @(posedge aclk);
            chk_val("edge start", 1, samp_starts > n0);
            wr(c2, {3'h0, s[0], 4'hd});
            do rd(c1); while (rd_data[2] !== 1'b0);
            n0 = samp_starts;
            repeat (130) @(posedge aclk);
            chk_val("edge stopped", n0, samp_starts);
            run <= 2'b00;
            wr(c1, 8'h51);
            repeat (20) @(posedge aclk);
            chk_val("soft start", n0 + 1, samp_starts);
        end
    endtask : t_cont

    task automatic t_conv;
        wr(c1, 8'h50);
        wr(c2, 8'h09);
        lvl <= 8'h5a;
        wr(c1, 8'h51);
        repeat (60) @(posedge aclk);
        rdchk(cd, 8'h5a, "conversion result");
        rdchk(c1, 8'h58, "conversion flag");
        lvl <= 8'h11;
        wr(cd, 8'h33);
        rdchk(cd, 8'h5a, "result held");
        wr(c1, 8'h50);
        wr(c2, 8'h0d);
        wr(cd, 8'h33);
        rdchk(cd, 8'h5a, "read path in sense");
    endtask : t_conv

    task automatic t_stop;
        // Second start lands on the completing cycle of a matching sense
        wr(c1, 8'h51);
        repeat (9) @(posedge aclk);
        wr(c1, 8'h51);
        rdchk(c1, 8'h54, "restart flag");
        stop_mode <= 1'b1;
        @(posedge aclk);
        stop_mode <= 1'b0;
        @(posedge aclk);
        chk_val("sampling after stop", 0, sh_sampling);
        rdchk(c1, 8'h00, "ctl1 after stop");
        rdchk(c2, 8'h01, "ctl2 after stop");
    endtask : t_stop

    task automatic final_report;
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_sense;
        t_irq;
        t_cont;
        t_conv;
        t_stop;
        final_report;
    end

    // Watchdog well beyond the expected run of about 1200 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        final_report;
    end
endmodule : adc_sense_compare_control_tb_top
`default_nettype wire
